// ===== shared/xfer_pkg.sv
// Package with opcodes, widths, reset values and carrier types of the transfer decoder
package xfer_pkg;
	localparam int OPCODE_W = 10;
	localparam int NIBBLE_W = 4;
	localparam int RELOAD_W = 8;
	// Opcodes of the accumulator transfer instructions
	localparam logic [OPCODE_W-1:0] OP_LOAD_PULLUP_CTL1 = 10'h22E;
	localparam logic [OPCODE_W-1:0] OP_LOAD_TIMER_RELOAD1 = 10'h23F;
	localparam logic [OPCODE_W-1:0] OP_LOAD_CLOCK_CTL = 10'h209;
	localparam logic [OPCODE_W-1:0] OP_LOAD_INT_CTL1 = 10'h03F;
	// Field positions inside timer reload register 1
	localparam int RELOAD_HI_MSB = 7;
	localparam int RELOAD_HI_LSB = 4;
	localparam int RELOAD_LO_MSB = 3;
	localparam int RELOAD_LO_LSB = 0;
	// Reset values
	localparam logic [NIBBLE_W-1:0] PULLUP_CTL1_RST = 4'h0;
	localparam logic [RELOAD_W-1:0] TIMER_RELOAD1_RST = 8'h00;
	localparam logic [NIBBLE_W-1:0] CLOCK_CTL_RST = 4'h0;
	localparam logic [NIBBLE_W-1:0] INT_CTL1_RST = 4'h0;
	// Instruction timing: words and machine cycles per transfer
	localparam int INSTR_WORDS = 1;
	localparam int INSTR_CYCLES = 1;

	// One-hot selection of the decoded transfer
	typedef struct packed {
		logic load_pullup_ctl1_from_acc;
		logic load_timer_reload1_from_acc_b;
		logic load_clock_ctl_from_acc;
		logic load_int_ctl1_from_acc;
	} xfer_sel_t;

	// Peripheral control registers written by the transfers
	typedef struct packed {
		logic [NIBBLE_W-1:0] pullup_control_1;
		logic [RELOAD_W-1:0] timer_reload_1;
		logic [NIBBLE_W-1:0] clock_control_reg;
		logic [NIBBLE_W-1:0] interrupt_control_1;
	} periph_regs_t;
endpackage

// ===== hdl/xfer_opcode_match.sv
// Opcode matcher that turns an instruction word into a one-hot transfer selection
`timescale 1ns/100ps
`default_nettype none
module xfer_opcode_match (
	input  wire logic [xfer_pkg::OPCODE_W-1:0] instr_word,
	input  wire logic                          instr_valid,
	output xfer_pkg::xfer_sel_t                sel
);
	// Exact compare against one opcode, qualified by the valid strobe
	function automatic logic op_is(input logic [xfer_pkg::OPCODE_W-1:0] word,
			input logic [xfer_pkg::OPCODE_W-1:0] op, input logic vld);
		op_is = vld && (word == op);
	endfunction

	// Full 10-bit decode of each transfer
	always_comb begin
		sel.load_pullup_ctl1_from_acc =
			op_is(instr_word, xfer_pkg::OP_LOAD_PULLUP_CTL1, instr_valid);
		sel.load_timer_reload1_from_acc_b =
			op_is(instr_word, xfer_pkg::OP_LOAD_TIMER_RELOAD1, instr_valid);
		sel.load_clock_ctl_from_acc =
			op_is(instr_word, xfer_pkg::OP_LOAD_CLOCK_CTL, instr_valid);
		sel.load_int_ctl1_from_acc =
			op_is(instr_word, xfer_pkg::OP_LOAD_INT_CTL1, instr_valid);
	end
endmodule // xfer_opcode_match
`default_nettype wire

// ===== hdl/accumulator_transfer_decode.sv
// Decode and execute of accumulator transfers into peripheral control registers
`timescale 1ns/100ps
`default_nettype none
module accumulator_transfer_decode (
	input  wire logic                          clk_sys,
	input  wire logic                          sys_rst,
	input  wire logic                          instr_valid,
	input  wire logic [xfer_pkg::OPCODE_W-1:0] instr_word,
	input  wire logic [xfer_pkg::NIBBLE_W-1:0] acc_in,
	input  wire logic [xfer_pkg::NIBBLE_W-1:0] b_in,
	input  wire logic                          carry_in,
	output logic                               instr_hit,
	output xfer_pkg::periph_regs_t             periph_regs,
	output xfer_pkg::xfer_sel_t                load_strobe,
	output logic                               instr_done,
	output logic                               carry_flag,
	output logic                               skip_next
);
	typedef enum {ST_RESET, ST_RUN} exec_state_t;

	xfer_pkg::xfer_sel_t    sel;
	xfer_pkg::periph_regs_t regs_q;
	xfer_pkg::periph_regs_t regs_d;
	xfer_pkg::xfer_sel_t    strobe_q;
	xfer_pkg::xfer_sel_t    strobe_d;
	logic                   done_q;
	logic                   done_d;
	logic                   carry_q;
	logic                   carry_d;
	logic                   skip_q;
	logic                   skip_d;
	exec_state_t            state_q;
	exec_state_t            state_d;

	// Opcode decode of the word presented by the fetch stage
	xfer_opcode_match u_match (
		.instr_word  (instr_word),
		.instr_valid (instr_valid),
		.sel         (sel)
	);

	// Handshake back to the core: this block owns the instruction
	assign instr_hit = (state_q == ST_RUN) && (|sel);

	// Execution state: after reset the first cycle only settles the registers
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_RESET: begin
				state_d = ST_RUN;
			end
			ST_RUN: begin
				state_d = ST_RUN;
			end
			default: begin
				state_d = ST_RESET;
			end
		endcase
	end

	// Next values of the peripheral registers and status
	always_comb begin
		regs_d = regs_q;
		strobe_d = '0;
		done_d = 1'b0;
		carry_d = carry_q;
		skip_d = 1'b0;
		if (instr_hit) begin
			strobe_d = sel;
			done_d = 1'b1;
			carry_d = carry_in;
			if (sel.load_pullup_ctl1_from_acc) begin
				regs_d.pullup_control_1 = acc_in;
			end
			if (sel.load_timer_reload1_from_acc_b) begin
				regs_d.timer_reload_1[xfer_pkg::RELOAD_HI_MSB:xfer_pkg::RELOAD_HI_LSB] = b_in;
				regs_d.timer_reload_1[xfer_pkg::RELOAD_LO_MSB:xfer_pkg::RELOAD_LO_LSB] = acc_in;
			end
			if (sel.load_clock_ctl_from_acc) begin
				regs_d.clock_control_reg = acc_in;
			end
			if (sel.load_int_ctl1_from_acc) begin
				regs_d.interrupt_control_1 = acc_in;
			end
		end
	end

	// Register stage with synchronous reset
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			regs_q.pullup_control_1 <= xfer_pkg::PULLUP_CTL1_RST;
			regs_q.timer_reload_1 <= xfer_pkg::TIMER_RELOAD1_RST;
			regs_q.clock_control_reg <= xfer_pkg::CLOCK_CTL_RST;
			regs_q.interrupt_control_1 <= xfer_pkg::INT_CTL1_RST;
			strobe_q <= '0;
			done_q <= 1'b0;
			carry_q <= 1'b0;
			skip_q <= 1'b0;
			state_q <= ST_RESET;
		end else begin
			regs_q <= regs_d;
			strobe_q <= strobe_d;
			done_q <= done_d;
			carry_q <= carry_d;
			skip_q <= skip_d;
			state_q <= state_d;
		end
	end

	// Outputs straight from flip-flops
	assign periph_regs = regs_q;
	assign load_strobe = strobe_q;
	assign instr_done = done_q;
	assign carry_flag = carry_q;
	assign skip_next = skip_q;

	// Helper: a transfer is accepted this cycle
	sequence take_pullup;
		instr_hit && sel.load_pullup_ctl1_from_acc;
	endsequence

	sequence take_reload;
		instr_hit && sel.load_timer_reload1_from_acc_b;
	endsequence

	sequence take_intctl;
		instr_hit && sel.load_int_ctl1_from_acc;
	endsequence

	// Pull-up control 1 takes the accumulator one edge later
	AST_PULLUP_LOAD: assert property (@(posedge clk_sys) disable iff (sys_rst)
		take_pullup |=> periph_regs.pullup_control_1 == $past(acc_in))
		else $error("pull-up control 1 did not take the accumulator");

	// Opcode recognised only for the exact word
	AST_PULLUP_DECODE: assert property (@(posedge clk_sys) disable iff (sys_rst)
		sel.load_pullup_ctl1_from_acc |-> instr_valid && instr_word == xfer_pkg::OP_LOAD_PULLUP_CTL1)
		else $error("pull-up transfer decoded from a wrong word");

	// High nibble of reload 1 comes from B
	AST_RELOAD_HI: assert property (@(posedge clk_sys) disable iff (sys_rst)
		take_reload |=> periph_regs.timer_reload_1[7:4] == $past(b_in))
		else $error("reload 1 high nibble is not B");

	// Low nibble of reload 1 comes from A in the same edge
	AST_RELOAD_LO: assert property (@(posedge clk_sys) disable iff (sys_rst)
		take_reload |=> periph_regs.timer_reload_1[3:0] == $past(acc_in)
			&& load_strobe.load_timer_reload1_from_acc_b)
		else $error("reload 1 low nibble is not A");

	// Reload 1 stays put without its transfer
	AST_RELOAD_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!(instr_hit && sel.load_timer_reload1_from_acc_b) |=> $stable(periph_regs.timer_reload_1))
		else $error("reload 1 changed without a transfer");

	// Interrupt control 1 takes the accumulator
	AST_INTCTL_LOAD: assert property (@(posedge clk_sys) disable iff (sys_rst)
		take_intctl |=> periph_regs.interrupt_control_1 == $past(acc_in))
		else $error("interrupt control 1 did not take the accumulator");

	// A transfer followed by an idle cycle
	sequence lone_hit;
		instr_hit ##1 !instr_hit;
	endsequence

	// Done high for one cycle, then low again
	sequence done_pulse;
		instr_done ##1 !instr_done;
	endsequence

	// One cycle: done pulses for exactly one cycle after a lone transfer
	AST_ONE_CYCLE: assert property (@(posedge clk_sys) disable iff (sys_rst)
		lone_hit |-> done_pulse)
		else $error("transfer did not complete in one cycle");

	// Carry unchanged and never a skip
	AST_CARRY_SKIP: assert property (@(posedge clk_sys) disable iff (sys_rst)
		instr_hit |=> carry_flag == $past(carry_in) && !skip_next)
		else $error("transfer disturbed carry or requested a skip");

	// Pull-up control 1 stays put without its transfer
	AST_PULLUP_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!(instr_hit && sel.load_pullup_ctl1_from_acc) |=> $stable(periph_regs.pullup_control_1))
		else $error("pull-up control 1 changed without a transfer");

	// Interrupt control 1 stays put without its transfer
	AST_INTCTL_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!(instr_hit && sel.load_int_ctl1_from_acc)
			|=> $stable(periph_regs.interrupt_control_1))
		else $error("interrupt control 1 changed without a transfer");

	// Reload 1 is decoded only from its exact word
	AST_RELOAD_DECODE: assert property (@(posedge clk_sys) disable iff (sys_rst)
		sel.load_timer_reload1_from_acc_b
			|-> instr_valid && instr_word == xfer_pkg::OP_LOAD_TIMER_RELOAD1)
		else $error("reload 1 transfer decoded from a wrong word");

	// Interrupt control 1 is decoded only from its exact word
	AST_INTCTL_DECODE: assert property (@(posedge clk_sys) disable iff (sys_rst)
		sel.load_int_ctl1_from_acc |-> instr_valid && instr_word == xfer_pkg::OP_LOAD_INT_CTL1)
		else $error("interrupt control 1 transfer decoded from a wrong word");

	// Each accepted transfer raises exactly its own strobe one cycle later
	AST_STROBE_MATCH: assert property (@(posedge clk_sys) disable iff (sys_rst)
		instr_hit |=> load_strobe == $past(sel) && instr_done)
		else $error("load strobe does not match the accepted transfer");

	// Nothing accepted means no strobe and no done in the next cycle
	AST_STROBE_IDLE: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!instr_hit |=> !(|load_strobe) && !instr_done)
		else $error("strobe or done without an accepted transfer");

	// Done never shows without a transfer in the cycle before
	AST_DONE_AFTER_HIT: assert property (@(posedge clk_sys) disable iff (sys_rst)
		instr_done |-> $past(instr_hit))
		else $error("done raised without a transfer");
endmodule // accumulator_transfer_decode
`default_nettype wire

// ===== verif/core_fetch_model.sv
// Model of the core fetch stage that presents words and operands
`timescale 1ns/100ps
`default_nettype none
module core_fetch_model (
	input  wire logic                     clk_sys,
	output logic                          instr_valid,
	output logic [xfer_pkg::OPCODE_W-1:0] instr_word,
	output logic [xfer_pkg::NIBBLE_W-1:0] acc_in,
	output logic [xfer_pkg::NIBBLE_W-1:0] b_in,
	output logic                          carry_in
);
	// Nothing presented at time zero
	initial begin
		instr_valid = 1'b0;
		instr_word = 10'h000;
		acc_in = 4'h0;
		b_in = 4'h0;
		carry_in = 1'b0;
	end
	// Present one word for one cycle, shortly after the rising edge
	task automatic present(input logic v, input logic [9:0] w, input logic [3:0] a,
		input logic [3:0] b, input logic c);
		@(posedge clk_sys);
		#1;
		instr_valid = v;
		instr_word = w;
		acc_in = a;
		b_in = b;
		carry_in = c;
	endtask
endmodule // core_fetch_model
`default_nettype wire

// ===== verif/accumulator_transfer_decode_tb.sv
// Self-checking bench for the accumulator transfer decoder
`timescale 1ns/100ps
`default_nettype none
module accumulator_transfer_decode_tb;
	logic                          clk_sys = 1'b0;
	logic                          sys_rst = 1'b1;
	logic                          instr_valid;
	logic [xfer_pkg::OPCODE_W-1:0] instr_word;
	logic [3:0]                    acc_in;
	logic [3:0]                    b_in;
	logic                          carry_in;
	logic                          instr_hit;
	xfer_pkg::periph_regs_t        periph_regs;
	xfer_pkg::xfer_sel_t           load_strobe;
	logic                          instr_done;
	logic                          carry_flag;
	logic                          skip_next;
	xfer_pkg::periph_regs_t        exp_regs = '0;
	xfer_pkg::xfer_sel_t           exp_sel = '0;
	logic                          exp_done = 1'b0;
	logic                          exp_cy = 1'b0;
	int                            err_count = 0;
	int                            checked = 0;
	// Clock of 100 ns period
	always #50 clk_sys = ~clk_sys;
	core_fetch_model fetch (.clk_sys(clk_sys), .instr_valid(instr_valid),
		.instr_word(instr_word), .acc_in(acc_in), .b_in(b_in), .carry_in(carry_in));
	accumulator_transfer_decode uut (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.instr_valid(instr_valid), .instr_word(instr_word), .acc_in(acc_in), .b_in(b_in),
		.carry_in(carry_in), .instr_hit(instr_hit), .periph_regs(periph_regs),
		.load_strobe(load_strobe), .instr_done(instr_done), .carry_flag(carry_flag),
		.skip_next(skip_next));
	// Compare the peripheral register bank
	task automatic cmp_regs(input xfer_pkg::periph_regs_t got,
		input xfer_pkg::periph_regs_t exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: regs got %h expected %h", $time, got, exp);
		end
	endtask
	// Compare the load strobes
	task automatic cmp_sel(input xfer_pkg::xfer_sel_t got, input xfer_pkg::xfer_sel_t exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: strobe got %h expected %h", $time, got, exp);
		end
	endtask
	// Compare done, carry and skip together
	task automatic cmp_status(input logic [2:0] got, input logic [2:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: status got %h expected %h", $time, got, exp);
		end
	endtask
	// Compare the combinational hit
	task automatic cmp_hit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: hit got %h expected %h", $time, got, exp);
		end
	endtask
	// Present one word, judge the previous one, then predict this one
	task automatic step(input logic v, input logic [9:0] w, input logic [3:0] a,
		input logic [3:0] b, input logic c);
		logic hit;
		fetch.present(v, w, a, b, c);
		#1;
		cmp_regs(periph_regs, exp_regs);
		cmp_sel(load_strobe, exp_sel);
		cmp_status({instr_done, carry_flag, skip_next}, {exp_done, exp_cy, 1'b0});
		hit = v && (w == 10'h22E || w == 10'h23F || w == 10'h209 || w == 10'h03F);
		cmp_hit(instr_hit, hit);
		exp_sel = '0;
		exp_done = hit;
		if (hit) begin
			exp_cy = c;
			exp_sel = {w == 10'h22E, w == 10'h23F, w == 10'h209, w == 10'h03F};
		end
		if (exp_sel.load_pullup_ctl1_from_acc) exp_regs.pullup_control_1 = a;
		if (exp_sel.load_timer_reload1_from_acc_b) exp_regs.timer_reload_1 = {b, a};
		if (exp_sel.load_clock_ctl_from_acc) exp_regs.clock_control_reg = a;
		if (exp_sel.load_int_ctl1_from_acc) exp_regs.interrupt_control_1 = a;
	endtask
	// Every transfer back to back, reload halves at opposite extremes
	task automatic scen_back_to_back();
		step(1'b1, 10'h22E, 4'hA, 4'h5, 1'b1);
		step(1'b1, 10'h23F, 4'h0, 4'hF, 1'b0);
		step(1'b1, 10'h209, 4'h6, 4'h9, 1'b1);
		step(1'b1, 10'h03F, 4'hC, 4'h3, 1'b0);
		step(1'b1, 10'h23F, 4'hF, 4'h1, 1'b1);
	endtask
	// Neighbouring words and unqualified transfers change nothing
	task automatic scen_refused();
		step(1'b0, 10'h22E, 4'h3, 4'h3, 1'b0);
		step(1'b1, 10'h22F, 4'h5, 4'h7, 1'b0);
		step(1'b1, 10'h23E, 4'h9, 4'h2, 1'b0);
		step(1'b0, 10'h03F, 4'h1, 4'h4, 1'b0);
		step(1'b0, 10'h3C0, 4'h0, 4'h0, 1'b1);
		step(1'b0, 10'h000, 4'h0, 4'h0, 1'b0);
	endtask
	// Mid-run reset clears the bank, and the settle cycle after it refuses a transfer
	task automatic scen_reset_settle();
		fetch.present(1'b1, xfer_pkg::OP_LOAD_PULLUP_CTL1, 4'h7, 4'h0, 1'b1);
		sys_rst = 1'b1;
		fetch.present(1'b1, xfer_pkg::OP_LOAD_PULLUP_CTL1, 4'h7, 4'h0, 1'b1);
		sys_rst = 1'b0;
		#1;
		cmp_regs(periph_regs, '0);
		cmp_status({instr_done, carry_flag, skip_next}, 3'h0);
		cmp_hit(instr_hit, 1'b0);
		exp_regs = '0;
		exp_sel = '0;
		exp_done = 1'b0;
		exp_cy = 1'b0;
		step(1'b1, xfer_pkg::OP_LOAD_PULLUP_CTL1, 4'h7, 4'h0, 1'b1);
		step(1'b0, 10'h000, 4'h0, 4'h0, 1'b0);
	endtask
	// Print counts and the verdict, then stop
	task automatic tally_and_finish();
		$display("checked %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Reset for five cycles, then the scenarios
	initial begin
		repeat (5) @(posedge clk_sys);
		#1;
		sys_rst = 1'b0;
		@(posedge clk_sys);
		scen_back_to_back();
		scen_refused();
		scen_reset_settle();
		tally_and_finish();
	end
	// Watchdog well beyond the expected run
	initial begin
		#100000;
		err_count++;
		tally_and_finish();
	end
endmodule // accumulator_transfer_decode_tb
`default_nettype wire
